//--- core/dbs_pkg.sv
`default_nettype none
package dbs_pkg;
  // Array shape
  localparam int NUM_BLK = 8;
  localparam int HALF_BLK = 4;
  localparam int COMM_FIRST = 4;
  localparam int BCAST_BLK = 3;

  // Function register fields
  localparam int FN_FUNC_LSB = 0;
  localparam int FN_FUNC_W = 3;
  localparam int FN_MODE0_BIT = 3;
  localparam int FN_MODE1_BIT = 4;
  localparam int FN_END_BIT = 5;
  localparam logic [7:0] FN_RESET = 8'h00;

  // Input register fields
  localparam int IN_CLK_LSB = 0;
  localparam int IN_DATA_LSB = 4;
  localparam int SEL_W = 4;
  localparam logic [7:0] IN_RESET = 8'h00;

  // Function codes
  localparam logic [2:0] FUNC_TIMER = 3'h0;
  localparam logic [2:0] FUNC_COUNTER = 3'h1;
  localparam logic [2:0] FUNC_CRC = 3'h2;
  localparam logic [2:0] FUNC_RSVD_A = 3'h3;
  localparam logic [2:0] FUNC_DEADBAND = 3'h4;
  localparam logic [2:0] FUNC_UART = 3'h5;
  localparam logic [2:0] FUNC_SPI = 3'h6;
  localparam logic [2:0] FUNC_RSVD_B = 3'h7;

  // Data/enable select codes
  localparam logic [3:0] DSEL_ZERO = 4'h0;
  localparam logic [3:0] DSEL_ONE = 4'h1;
  localparam logic [3:0] DSEL_BCAST = 4'h2;
  localparam logic [3:0] DSEL_CHAIN = 4'h3;
  // Upper two select bits name the source group
  localparam logic [1:0] GRP_LOCAL = 2'h0;
  localparam logic [1:0] GRP_CMP = 2'h1;
  localparam logic [1:0] GRP_GOUT = 2'h2;
  localparam logic [1:0] GRP_GIN = 2'h3;

  // Clock select codes
  localparam logic [3:0] CSEL_OFF = 4'h0;
  localparam logic [3:0] CSEL_GOUT_FAR = 4'h1;
  localparam logic [3:0] CSEL_BCAST = 4'h2;
  localparam logic [3:0] CSEL_PREV = 4'h3;
  localparam logic [3:0] CSEL_DOUBLED = 4'h4;
  localparam logic [3:0] CSEL_DIV_ONE = 4'h5;
  localparam logic [3:0] CSEL_DIV_TWO = 4'h6;
  localparam logic [3:0] CSEL_LOW_SPEED = 4'h7;

  // Register indices; byte address is four times the index
  localparam logic [7:0] FN_IDX [NUM_BLK] = '{8'h24, 8'h20, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
  localparam logic [7:0] IN_IDX [NUM_BLK] = '{8'h21, 8'h25, 8'h29, 8'h2D, 8'h31, 8'h35, 8'h39, 8'h3D};
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;
endpackage
`default_nettype wire

//--- core/dbs_cfg_bank.sv
`default_nettype none
// Functional notes
// (RULE1) Function bits [2:0] pick timer, counter, CRC, deadband, UART, SPI; two codes reserved.
// (RULE2) UART and SPI codes work only in communication blocks four to seven.
// (RULE3) Bit 5 marks chain end or unchained; software keeps it set in block seven.
// (RULE4) Timer/counter: mode bit 1 picks less-or-equal (0) or strict less-than (1).
// (RULE5) Timer/counter: mode bit 0 picks terminal count (0) or compare (1) interrupt.
// (RULE6) Mode bits do nothing for CRC/sequencer and deadband functions.
// (RULE7) UART transmit: mode bit 1 picks holding empty (0) or complete (1) interrupt.
// (RULE8) UART: mode bit 0 picks receiver (0) or transmitter (1).
// (RULE9) SPI: mode bit 1 zero gives role-specific interrupt, one gives transfer-complete interrupt.
// (RULE10) SPI: mode bit 0 picks master (0) or slave (1).
// (RULE11) Input register: clock select in [3:0], data/enable select in [7:4].
// (RULE12) Data select: constants, block 3, chain, comparators, global outputs, global inputs.
// (RULE13) Chain selection takes data, enable and zero-detect from the previous block.
// (RULE14) Blocks 0-3 reach global lines 0-3; blocks 4-7 reach lines 4-7.
// (RULE15) Clock select: off, far global output, block 3, previous, system clocks, globals.
// (RULE16) Data from global inputs passes a two-stage synchroniser before use.
// (RULE17) Clocks from global inputs are routed without synchronisation.
// (RULE18) Data serves as timer capture edge, count enable, serial data, kill or line.
// (RULE19) Only timer, counter and CRC/sequencer functions may chain.
// (RULE20) Primary outputs feed neighbours' previous-block and block-3 clock selections.
// (RULE21) Reserved function leaves block idle, yet register reads back written value.
module dbs_cfg_bank
  import dbs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] glb_in,
  input wire logic [7:0] glb_out,
  input wire logic [3:0] cmp_in,
  input wire logic doubled_system_clock,
  input wire logic divided_system_clock_one,
  input wire logic divided_system_clock_two,
  input wire logic low_speed_clock,
  input wire logic [7:0] blk_primary,
  input wire logic [7:0] chain_data_in,
  input wire logic [7:0] chain_en_in,
  input wire logic [7:0] chain_zero_in,
  input wire logic [7:0] evt_tc,
  input wire logic [7:0] evt_cmp,
  input wire logic [7:0] evt_tx_empty,
  input wire logic [7:0] evt_tx_done,
  input wire logic [7:0] evt_rx_full,
  input wire logic [7:0] evt_spi_done,
  output logic [7:0][2:0] blk_func,
  output logic [7:0] blk_active,
  output logic [7:0] blk_chain_end,
  output logic [7:0] blk_chained,
  output logic [7:0] blk_cmp_lt,
  output logic [7:0] blk_uart_tx,
  output logic [7:0] blk_spi_slave,
  output logic [7:0] blk_clk,
  output logic [7:0] blk_data,
  output logic [7:0] blk_enable,
  output logic [7:0] blk_zero,
  output logic [7:0] blk_capture,
  output logic [7:0] blk_irq
);

  if (ADDR_W < IDX_LSB + IDX_W) begin : g_addr_chk
    $error("ADDR_W too narrow for the register map");
  end

  logic [7:0] fn_reg [NUM_BLK];
  logic [7:0] in_reg [NUM_BLK];
  logic [7:0] gin_s1_reg;
  logic [7:0] gin_s2_reg;
  logic [3:0] cmp_s1_reg;
  logic [3:0] cmp_s2_reg;
  logic [7:0] data_reg;
  logic [7:0] enable_reg;
  logic [7:0] zero_reg;
  logic [7:0] capture_reg;
  logic [7:0] irq_reg;
  logic [31:0] prdata_reg;

  logic [IDX_W-1:0] reg_idx;
  logic [7:0] hit_fn;
  logic [7:0] hit_in;
  logic [7:0] rd_acc [NUM_BLK+1];
  logic addr_mapped;
  logic apb_setup;
  logic apb_write;
  logic [7:0] data_next;
  logic [7:0] enable_next;
  logic [7:0] zero_next;
  logic [7:0] irq_next;

  // APB decode; zero wait states
  assign reg_idx = paddr[IDX_LSB +: IDX_W];
  assign addr_mapped = |{hit_fn, hit_in};
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite & addr_mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped;
  assign prdata = prdata_reg;
  assign rd_acc[0] = 8'h00;

  // Two-stage synchronisers for pin and analog data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gin_s1_reg <= 8'h00;
      gin_s2_reg <= 8'h00;
      cmp_s1_reg <= 4'h0;
      cmp_s2_reg <= 4'h0;
    end else begin
      gin_s1_reg <= glb_in;
      gin_s2_reg <= gin_s1_reg;
      cmp_s1_reg <= cmp_in;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata_reg <= {24'h00_0000, rd_acc[NUM_BLK]};
    end
  end

  for (genvar i = 0; i < NUM_BLK; i++) begin : g_blk
    localparam int GBASE = (i / HALF_BLK) * HALF_BLK;
    localparam int GFAR = ((i / HALF_BLK) == 0) ? HALF_BLK : 0;
    localparam bit IS_COMM = (i >= COMM_FIRST);
    logic [2:0] func;
    logic mode0;
    logic mode1;
    logic [3:0] dsel;
    logic [3:0] csel;
    logic [2:0] gidx;
    logic code_ok;
    logic is_tmr_cnt;
    logic chainable;
    logic prev_data;
    logic prev_en;
    logic prev_zero;
    logic prev_primary;
    logic data_mux;
    logic clk_mux;
    logic grp_sel;

    // Address hits and read-back merge
    assign hit_fn[i] = (reg_idx == FN_IDX[i]);
    assign hit_in[i] = (reg_idx == IN_IDX[i]);
    // (RULE21) reserved codes still read back
    assign rd_acc[i+1] = rd_acc[i] | ({8{hit_fn[i]}} & fn_reg[i]) | ({8{hit_in[i]}} & in_reg[i]);

    // Register storage
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fn_reg[i] <= FN_RESET;
        in_reg[i] <= IN_RESET;
      end else if (apb_write) begin
        if (hit_fn[i]) begin
          fn_reg[i] <= pwdata[7:0];
        end
        if (hit_in[i]) begin
          in_reg[i] <= pwdata[7:0];
        end
      end
    end

    // (RULE1) field split of the function register
    assign func = fn_reg[i][FN_FUNC_LSB +: FN_FUNC_W];
    assign mode0 = fn_reg[i][FN_MODE0_BIT];
    assign mode1 = fn_reg[i][FN_MODE1_BIT];
    // (RULE11) clock and data select fields
    assign csel = in_reg[i][IN_CLK_LSB +: SEL_W];
    assign dsel = in_reg[i][IN_DATA_LSB +: SEL_W];
    // (RULE2) comm codes rejected on basic blocks
    assign code_ok = (func != FUNC_RSVD_A) && (func != FUNC_RSVD_B) &&
                     (IS_COMM || ((func != FUNC_UART) && (func != FUNC_SPI)));
    assign is_tmr_cnt = (func == FUNC_TIMER) || (func == FUNC_COUNTER);
    // (RULE19) chain-capable functions
    assign chainable = is_tmr_cnt || (func == FUNC_CRC);

    // Block status outputs
    assign blk_func[i] = func;
    // (RULE21) reserved code idles the block
    assign blk_active[i] = code_ok;
    // (RULE3) last block always ends the array
    assign blk_chain_end[i] = fn_reg[i][FN_END_BIT] || (i == NUM_BLK - 1);
    // (RULE4) compare type
    assign blk_cmp_lt[i] = code_ok && is_tmr_cnt && mode1;
    // (RULE8) UART direction
    assign blk_uart_tx[i] = code_ok && (func == FUNC_UART) && mode0;
    // (RULE10) SPI role
    assign blk_spi_slave[i] = code_ok && (func == FUNC_SPI) && mode0;
    // (RULE13) chain only when the function allows it
    assign blk_chained[i] = code_ok && chainable && (dsel == DSEL_CHAIN);

    // Previous block signals; block 0 has none
    if (i == 0) begin : g_first
      assign prev_data = 1'b0;
      assign prev_en = 1'b0;
      assign prev_zero = 1'b0;
      assign prev_primary = 1'b0;
    end else begin : g_rest
      assign prev_data = chain_data_in[i-1];
      assign prev_en = chain_en_in[i-1];
      assign prev_zero = chain_zero_in[i-1];
      // (RULE20) neighbour primary output as clock
      assign prev_primary = blk_primary[i-1];
    end

    // (RULE14) global line index within this half
    assign gidx = 3'(GBASE) + {1'b0, dsel[1:0]};
    // (RULE12) data/enable source selection
    assign grp_sel = (dsel[3:2] == GRP_CMP) ? cmp_s2_reg[dsel[1:0]] :
                     (dsel[3:2] == GRP_GOUT) ? glb_out[gidx] :
                     gin_s2_reg[gidx];
    // (RULE16) global inputs read only after sync
    assign data_mux = (dsel == DSEL_ZERO) ? 1'b0 :
                      (dsel == DSEL_ONE) ? 1'b1 :
                      (dsel == DSEL_BCAST) ? blk_primary[BCAST_BLK] :
                      (dsel == DSEL_CHAIN) ? (chainable & prev_data) :
                      grp_sel;
    // (RULE13) chained blocks inherit data, enable, zero
    assign data_next[i] = code_ok & data_mux;
    assign enable_next[i] = blk_chained[i] ? prev_en : data_next[i];
    assign zero_next[i] = blk_chained[i] & prev_zero;

    // (RULE15) clock source selection
    // (RULE17) global input clocks routed raw
    assign clk_mux = (csel == CSEL_OFF) ? 1'b0 :
                     (csel == CSEL_GOUT_FAR) ? glb_out[GFAR] :
                     (csel == CSEL_BCAST) ? blk_primary[BCAST_BLK] :
                     (csel == CSEL_PREV) ? prev_primary :
                     (csel == CSEL_DOUBLED) ? doubled_system_clock :
                     (csel == CSEL_DIV_ONE) ? divided_system_clock_one :
                     (csel == CSEL_DIV_TWO) ? divided_system_clock_two :
                     (csel == CSEL_LOW_SPEED) ? low_speed_clock :
                     csel[2] ? glb_in[3'(GBASE) + {1'b0, csel[1:0]}] :
                     glb_out[3'(GBASE) + {1'b0, csel[1:0]}];
    assign blk_clk[i] = code_ok & clk_mux;

    // (RULE5) timer/counter interrupt source
    // (RULE6) CRC and deadband ignore mode bits
    // (RULE7) UART transmit interrupt choice
    // (RULE9) SPI interrupt choice
    assign irq_next[i] = !code_ok ? 1'b0 :
                         is_tmr_cnt ? (mode0 ? evt_cmp[i] : evt_tc[i]) :
                         (func == FUNC_UART) ? (mode0 ? (mode1 ? evt_tx_done[i] : evt_tx_empty[i]) : evt_rx_full[i]) :
                         (func == FUNC_SPI) ? (mode1 ? evt_spi_done[i] : (mode0 ? evt_rx_full[i] : evt_tx_empty[i])) :
                         evt_tc[i];
  end

  // Per-block registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= 8'h00;
      enable_reg <= 8'h00;
      zero_reg <= 8'h00;
      capture_reg <= 8'h00;
      irq_reg <= 8'h00;
    end else begin
      data_reg <= data_next;
      enable_reg <= enable_next;
      zero_reg <= zero_next;
      // (RULE18) timer capture on rising data edge
      for (int k = 0; k < NUM_BLK; k++) begin
        capture_reg[k] <= blk_active[k] && (blk_func[k] == FUNC_TIMER) && data_next[k] && !data_reg[k];
      end
      irq_reg <= irq_next;
    end
  end

  assign blk_data = data_reg;
  assign blk_enable = enable_reg;
  assign blk_zero = zero_reg;
  assign blk_capture = capture_reg;
  assign blk_irq = irq_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic gin0_sel;
  logic [2:0] fn4_func;
  assign gin0_sel = (in_reg[0][IN_DATA_LSB +: SEL_W] == {GRP_GIN, 2'h0});
  assign fn4_func = fn_reg[4][FN_FUNC_LSB +: FN_FUNC_W];

  sequence s_fn4_write;
    psel && penable && pwrite && (reg_idx == FN_IDX[4]);
  endsequence

  sequence s_gin0_held;
    gin0_sel [*4];
  endsequence

  AST_FN_WRITE: assert property (s_fn4_write |=> (fn4_func == $past(pwdata[2:0], 1))) // RULE1
    else $error("function write not stored");
  AST_BASIC_NO_COMM: assert property (((blk_func[1] == FUNC_UART) || (blk_func[1] == FUNC_SPI)) |-> !blk_active[1]) // RULE2
    else $error("comm function active on basic block");
  AST_RSVD_IDLE: assert property ((blk_func[7] == FUNC_RSVD_B) ##1 (blk_func[7] == FUNC_RSVD_B) |-> !blk_irq[7] && !blk_clk[7]) // RULE21
    else $error("reserved function not idle");
  AST_TC_IRQ: assert property ((blk_func[0] == FUNC_TIMER) && !fn_reg[0][FN_MODE0_BIT] && evt_tc[0] |=> blk_irq[0]) // RULE5
    else $error("terminal count interrupt missing");
  AST_CMP_IRQ: assert property ((blk_func[1] == FUNC_COUNTER) && fn_reg[1][FN_MODE0_BIT] && !evt_cmp[1] |=> !blk_irq[1]) // RULE5
    else $error("counter interrupt without compare");
  AST_SPI_DONE: assert property ((blk_func[4] == FUNC_SPI) && fn_reg[4][FN_MODE1_BIT] && evt_spi_done[4] |=> blk_irq[4]) // RULE9
    else $error("spi complete interrupt missing");
  AST_CHAIN_DATA: assert property (blk_chained[5] |=> (blk_data[5] == $past(chain_data_in[4], 1))) // RULE13
    else $error("chained data not taken from previous block");
  AST_SYNC_GIN: assert property (s_gin0_held |-> (blk_data[0] == ($past(glb_in[0], 3) && blk_active[0]))) // RULE16
    else $error("global input data not synchronised in three cycles");
  AST_CLK_OFF: assert property ((in_reg[3][IN_CLK_LSB +: SEL_W] == CSEL_OFF) |-> !blk_clk[3]) // RULE15
    else $error("clock not off when disabled");
  AST_UNMAPPED: assert property (psel && penable && !addr_mapped |-> pslverr && pready) // RULE1
    else $error("unmapped access not flagged");

endmodule
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
module tb import dbs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // Bench-driven inputs and observed outputs
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] glb_in = '0, glb_out = '0, blk_primary = '0, chain_d = '0, chain_e = '0;
  logic [3:0] cmp_in = '0, sysclk = '0;
  logic [7:0] evt [6] = '{default: '0};
  logic [7:0][2:0] blk_func;
  logic [7:0] blk_active, blk_chain_end, blk_cmp_lt, blk_uart_tx, blk_spi_slave, blk_clk, blk_data;
  logic [7:0] blk_enable, blk_irq;
  int bad_count = 0, cmp_count = 0;
  // Block, function byte, event index and expected interrupt
  localparam logic [15:0] IRQ_T [16] = '{16'h0001, 16'h0002, 16'h0080, 16'h0083, 16'h40D5, 16'h40D6,
    16'h41D7, 16'h41D4, 16'h4059, 16'h4065, 16'h4068, 16'h40E9, 16'h40E4, 16'h416B, 16'h4164, 16'h4070};

  // Clock at 200 MHz
  always #2.5 pclk = ~pclk;

  dbs_cfg_bank #(.ADDR_W(12)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .glb_in(glb_in), .glb_out(glb_out), .cmp_in(cmp_in), .doubled_system_clock(sysclk[3]),
    .divided_system_clock_one(sysclk[2]), .divided_system_clock_two(sysclk[1]), .low_speed_clock(sysclk[0]),
    .blk_primary(blk_primary), .chain_data_in(chain_d), .chain_en_in(chain_e), .chain_zero_in(chain_e),
    .evt_tc(evt[0]), .evt_cmp(evt[1]), .evt_tx_empty(evt[2]), .evt_tx_done(evt[3]), .evt_rx_full(evt[4]),
    .evt_spi_done(evt[5]), .blk_func(blk_func), .blk_active(blk_active), .blk_chain_end(blk_chain_end),
    .blk_chained(), .blk_cmp_lt(blk_cmp_lt), .blk_uart_tx(blk_uart_tx), .blk_spi_slave(blk_spi_slave),
    .blk_clk(blk_clk), .blk_data(blk_data), .blk_enable(blk_enable), .blk_zero(), .blk_capture(),
    .blk_irq(blk_irq));

  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  function automatic logic [11:0] fa(int i);
    return {2'b00, FN_IDX[i], 2'b00};
  endfunction

  function automatic logic [11:0] ia(int i);
    return {2'b00, IN_IDX[i], 2'b00};
  endfunction

  // Source patterns; p flips every bit
  function automatic logic [7:0] pat(int k, bit p);
    logic [7:0] base [7] = '{8'h96, 8'hC3, 8'h05, 8'h05, 8'h0F, 8'hA6, 8'h3A};
    return base[k] ^ {8{p}};
  endfunction

  task automatic src(bit p);
    glb_in <= pat(0, p);
    glb_out <= pat(1, p);
    cmp_in <= 4'(pat(2, p));
    sysclk <= 4'(pat(3, p));
    blk_primary <= pat(4, p);
    chain_d <= pat(5, p);
    chain_e <= pat(6, p);
  endtask

  // Expected {clock, data} for select code s in both fields
  function automatic logic [1:0] ex(int b, logic [3:0] s, bit p);
    logic [7:0] gi, go, pr, cd;
    logic [3:0] sc, cm;
    int h, j;
    gi = pat(0, p);
    go = pat(1, p);
    cm = 4'(pat(2, p));
    sc = 4'(pat(3, p));
    pr = pat(4, p);
    cd = pat(5, p);
    h = (b < HALF_BLK) ? 0 : 4;
    j = h + s[1:0];
    case (s[3:2])
      2'd0: return {s == 0 ? 1'b0 : s == 1 ? go[4 - h] : s == 2 ? pr[3] : (b == 0 ? 1'b0 : pr[b - 1]),
                    s == 0 ? 1'b0 : s == 1 ? 1'b1 : s == 2 ? pr[3] : (b == 0 ? 1'b0 : cd[b - 1])};
      2'd1: return {sc[3 - s[1:0]], cm[s[1:0]]};
      2'd2: return {go[j], go[j]};
      default: return {gi[j], gi[j]};
    endcase
  endfunction

  task automatic t_reset();
    for (int i = 0; i < NUM_BLK; i++) begin
      apb(1'b0, fa(i), '0);
      chk("fn reset", rd, 32'h0);
      apb(1'b0, ia(i), '0);
      chk("in reset", rd, 32'h0);
    end
    chk("active", blk_active, 8'hFF);
    chk("end flag", blk_chain_end, 8'h80);
    apb(1'b0, 12'h000, '0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < NUM_BLK; i++) begin
      apb(1'b1, fa(i), 32'hFFFF_FFC8 | i);
      apb(1'b1, ia(i), 32'hFFFF_FF50 ^ i);
    end
    for (int i = 0; i < NUM_BLK; i++) begin
      apb(1'b0, fa(i), '0);
      chk("fn readback", {rd[31:1], err}, (32'hC8 | i) & 32'hFFFF_FFFE);
      chk("fn low bit", rd[0], i & 1);
      apb(1'b0, ia(i), '0);
      chk("in readback", rd, 32'h50 ^ i);
    end
    chk("end kept", blk_chain_end, 8'h80);
    for (int i = 0; i < NUM_BLK; i++) begin
      apb(1'b1, fa(i), '0);
      apb(1'b1, ia(i), '0);
    end
    $display("test registers done");
  endtask

  task automatic t_func();
    int b;
    logic c;
    for (int k = 0; k < 2; k++) begin
      for (int f = 0; f < 8; f++) begin
        b = k * 4;
        c = (b >= COMM_FIRST);
        apb(1'b1, fa(b), 32'h18 | f);
        chk("func", blk_func[b], f[2:0]);
        chk("active", blk_active[b], f != 3 && f != 7 && (f < 5 || c));
        chk("cmp type", blk_cmp_lt[b], f < 2);
        chk("uart dir", blk_uart_tx[b], f == 5 && c);
        chk("spi role", blk_spi_slave[b], f == 6 && c);
        chk("end", blk_chain_end[b], 1'b0);
      end
      apb(1'b1, fa(k * 4), '0);
    end
    $display("test function done");
  endtask

  task automatic t_irq();
    int b, e;
    for (int k = 0; k < 16; k++) begin
      b = IRQ_T[k][15:12];
      e = IRQ_T[k][3:1];
      apb(1'b1, fa(b), {24'h0, IRQ_T[k][11:4]});
      @(posedge pclk);
      evt[e][b] <= 1'b1;
      @(posedge pclk);
      evt[e][b] <= 1'b0;
      #1;
      chk("irq", blk_irq[b], IRQ_T[k][0]);
      @(posedge pclk);
      #1;
      chk("irq pulse", blk_irq, 8'h00);
    end
    apb(1'b1, fa(4), '0);
    apb(1'b1, fa(0), '0);
    $display("test interrupt done");
  endtask

  // Every select code on a low-half and a high-half block
  task automatic t_route();
    logic [1:0] o, n;
    logic [7:0] en;
    int b;
    for (int k = 0; k < 2; k++) begin
      b = k * 5;
      for (int s = 0; s < 16; s++) begin
        @(posedge pclk);
        src(1'b1);
        apb(1'b1, ia(b), {24'h0, s[3:0], s[3:0]});
        repeat (4) @(posedge pclk);
        for (int p = 0; p < 2; p++) begin
          o = ex(b, s[3:0], p == 0);
          n = ex(b, s[3:0], p == 1);
          en = pat(6, p == 1);
          @(posedge pclk);
          src(p == 1);
          @(posedge pclk);
          #1;
          chk("clk sel", blk_clk[b], n[1]);
          chk("data early", blk_data[b], (s >= 12 || s[3:2] == 2'd1) ? o[0] : n[0]);
          repeat (2) @(posedge pclk);
          #1;
          chk("data sel", blk_data[b], n[0]);
          if (s == 3) begin
            chk("chain en", blk_enable[b], b == 0 ? 1'b0 : en[b - 1]);
          end
        end
      end
    end
    $display("test routing done");
  endtask

  // Reset for 10 cycles, then the scenarios
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_func();
    t_irq();
    t_route();
    end_of_test();
  end
endmodule
`default_nettype wire
